// >>> ldcr_map.vh
// register map constants for the laser driver control register bank
// assumes inclusion by ldcr_regs.v only
`ifndef LDCR_MAP_VH
`define LDCR_MAP_VH

`define LDCR_OFS_MAIN 8'h00
`define LDCR_OFS_AUX 8'h01
`define LDCR_OFS_MOD_LO 8'h02
`define LDCR_OFS_MOD_HI 8'h03

`define LDCR_RST_MAIN 8'h00
`define LDCR_RST_AUX 8'h00
`define LDCR_RST_MOD_LO 2'h0
`define LDCR_RST_MOD_HI 8'h00

`define LDCR_MAIN_ENA 7
`define LDCR_MAIN_PDR_HI 6
`define LDCR_MAIN_PDR_LO 5
`define LDCR_MAIN_LOOP 4
`define LDCR_MAIN_FAULT_DETECT_ENABLE 3
`define LDCR_MAIN_POL 2
`define LDCR_MAIN_EQ 1
`define LDCR_MAIN_PHOTODIODE_POLARITY 0

`define LDCR_AUX_CROSSPOINT_TEMPCO_ENABLE 7
`define LDCR_AUX_CPR_HI 6
`define LDCR_AUX_CPR_LO 5
`define LDCR_AUX_CROSSPOINT_ENABLE 4
`define LDCR_AUX_OFFSET_CANCEL_DISABLE 3
`define LDCR_AUX_BPOL 2
`define LDCR_AUX_DMODE 1
`define LDCR_AUX_TERM 0

`define LDCR_MOD_LO_W 2
`define LDCR_BYTE_BITS 4'h8

`endif

// >>> ldcr_regs.v
// laser driver control register bank behind a 2-wire serial slave
// assumes scl/sda pins arrive asynchronously; fault_event is on mclk
`include "ldcr_map.vh"
`default_nettype none

module ldcr_regs #(
    // device address is arbitrary
    parameter [6:0] DEV_ADDR = 7'h2a
) (
    input wire mclk,
    input wire sys_rst,
    input wire scl_pin,
    input wire sda_pin,
    output wire sda_out,
    output wire sda_oe,
    input wire fault_event,
    output wire fault_latched,
    output wire fault_clear,
    output wire chip_enable,
    output wire [1:0] photodiode_range,
    output wire loop_mode_select,
    output wire fault_detect_enable,
    output wire output_polarity,
    output wire equalizer_enable,
    output wire photodiode_polarity,
    output wire crosspoint_tempco_enable,
    output wire [1:0] crosspoint_range,
    output wire crosspoint_enable,
    output wire offset_cancel_disable,
    output wire bias_polarity,
    output wire disable_mode_select,
    output wire serial_termination_select,
    output wire [9:0] modulation_code
);

    localparam [8:0] S_IDLE = 9'h001;
    localparam [8:0] S_DEV = 9'h002;
    localparam [8:0] S_DACK = 9'h004;
    localparam [8:0] S_RX = 9'h008;
    localparam [8:0] S_RACK = 9'h010;
    localparam [8:0] S_RD = 9'h020;
    localparam [8:0] S_MACK = 9'h040;
    localparam [8:0] S_WAIT = 9'h080;
    localparam [8:0] S_SPARE = 9'h100;
    // S_SPARE only rounds out the one-hot set; the default branch leaves it

    reg [7:0] main_control;
    reg [7:0] auxiliary_control;
    reg [1:0] modulation_code_low;
    reg [7:0] modulation_code_high;

    reg scl_m;
    reg scl_s;
    reg scl_q;
    reg sda_m;
    reg sda_s;
    reg sda_q;
    reg [8:0] state;
    reg [3:0] bit_cnt;
    reg [7:0] rx_sr;
    reg [7:0] tx_sr;
    reg [7:0] ptr;
    reg ptr_loaded;
    reg rw_bit;
    reg master_ack;
    reg sda_oe_q;
    reg ena_d;
    reg fault_q;
    reg fault_clear_q;
    reg sda_level;

    wire scl_rise;
    wire scl_fall;
    wire start_cond;
    wire stop_cond;
    wire ena_rise;
    wire [7:0] rd_cur;
    wire [7:0] rd_next;

    // combinational read mux; unmapped offsets read zero
    function [7:0] reg_read;
        input [7:0] ofs;
        begin
            case (ofs)
                `LDCR_OFS_MAIN: reg_read = main_control;
                `LDCR_OFS_AUX: reg_read = auxiliary_control;
                `LDCR_OFS_MOD_LO: reg_read = {6'h00, modulation_code_low};
                `LDCR_OFS_MOD_HI: reg_read = modulation_code_high;
                default: reg_read = 8'h00;
            endcase
        end
    endfunction

    // byte at the pointer, and the next one for the prefetch on a master ack
    assign rd_cur = reg_read(ptr);
    assign rd_next = reg_read(ptr + 8'h01);

    // edges are taken between the second and third flops only
    assign scl_rise = scl_s & ~scl_q;
    assign scl_fall = ~scl_s & scl_q;
    assign start_cond = scl_s & scl_q & sda_q & ~sda_s;
    assign stop_cond = scl_s & scl_q & ~sda_q & sda_s;

    // synchronizer flops come out of reset high so an idle bus is not taken for a start
    always @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            scl_m <= 1'b1;
            scl_s <= 1'b1;
            scl_q <= 1'b1;
            sda_m <= 1'b1;
            sda_s <= 1'b1;
            sda_q <= 1'b1;
            sda_level <= 1'b0;
        end else begin
            scl_m <= scl_pin;
            scl_s <= scl_m;
            scl_q <= scl_s;
            sda_m <= sda_pin;
            sda_s <= sda_m;
            sda_q <= sda_s;
            sda_level <= 1'b0;
        end
    end

    // serial protocol engine: pointer byte first, then auto-incrementing data
    always @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            state <= S_IDLE;
            bit_cnt <= 4'h0;
            rx_sr <= 8'h00;
            tx_sr <= 8'h00;
            ptr <= 8'h00;
            ptr_loaded <= 1'b0;
            rw_bit <= 1'b0;
            master_ack <= 1'b0;
            sda_oe_q <= 1'b0;
            // all control registers start at zero
            main_control <= `LDCR_RST_MAIN;
            auxiliary_control <= `LDCR_RST_AUX;
            modulation_code_low <= `LDCR_RST_MOD_LO;
            modulation_code_high <= `LDCR_RST_MOD_HI;
        // start and stop win over any state, so a confused frame always ends
        end else if (start_cond) begin
            state <= S_DEV;
            bit_cnt <= 4'h0;
            sda_oe_q <= 1'b0;
        end else if (stop_cond) begin
            state <= S_IDLE;
            sda_oe_q <= 1'b0;
        end else begin
            case (state)
                S_IDLE: begin
                    sda_oe_q <= 1'b0;
                end
                S_DEV: begin
                    // address bits shift in on rising clock edges
                    if (scl_rise) begin
                        rx_sr <= {rx_sr[6:0], sda_s};
                        bit_cnt <= bit_cnt + 4'h1;
                    end else if (scl_fall && bit_cnt == `LDCR_BYTE_BITS) begin
                        if (rx_sr[7:1] == DEV_ADDR) begin
                            rw_bit <= rx_sr[0];
                            sda_oe_q <= 1'b1;
                            state <= S_DACK;
                        end else begin
                            // wrong address: ignore the frame until the next start or stop
                            state <= S_WAIT;
                        end
                    end
                end
                S_DACK: begin
                    if (scl_fall) begin
                        bit_cnt <= 4'h0;
                        if (rw_bit) begin
                            // first read bit goes out on the falling edge that ends the ack
                            tx_sr <= rd_cur;
                            sda_oe_q <= ~rd_cur[7];
                            state <= S_RD;
                        end else begin
                            sda_oe_q <= 1'b0;
                            ptr_loaded <= 1'b0;
                            state <= S_RX;
                        end
                    end
                end
                S_RX: begin
                    if (scl_rise) begin
                        rx_sr <= {rx_sr[6:0], sda_s};
                        bit_cnt <= bit_cnt + 4'h1;
                    end else if (scl_fall && bit_cnt == `LDCR_BYTE_BITS) begin
                        sda_oe_q <= 1'b1;
                        state <= S_RACK;
                        if (!ptr_loaded) begin
                            // first byte after address and write is the pointer
                            ptr <= rx_sr;
                            ptr_loaded <= 1'b1;
                        end else begin
                            ptr <= ptr + 8'h01;
                            case (ptr)
                                `LDCR_OFS_MAIN: main_control <= rx_sr;
                                `LDCR_OFS_AUX: auxiliary_control <= rx_sr;
                                `LDCR_OFS_MOD_LO:
                                    modulation_code_low <= rx_sr[`LDCR_MOD_LO_W-1:0];
                                `LDCR_OFS_MOD_HI: modulation_code_high <= rx_sr;
                                // past the map: acked, then dropped
                                default: ptr <= ptr + 8'h01;
                            endcase
                        end
                    end
                end
                S_RACK: begin
                    // release the ack once the clock falls
                    if (scl_fall) begin
                        sda_oe_q <= 1'b0;
                        bit_cnt <= 4'h0;
                        state <= S_RX;
                    end
                end
                S_RD: begin
                    if (scl_rise) begin
                        bit_cnt <= bit_cnt + 4'h1;
                    end else if (scl_fall) begin
                        if (bit_cnt == `LDCR_BYTE_BITS) begin
                            // the ninth bit belongs to the master's ack
                            sda_oe_q <= 1'b0;
                            state <= S_MACK;
                        end else begin
                            tx_sr <= {tx_sr[6:0], 1'b0};
                            sda_oe_q <= ~tx_sr[6];
                        end
                    end
                end
                S_MACK: begin
                    if (scl_rise) begin
                        // a low ninth bit asks for another byte
                        master_ack <= ~sda_s;
                    end else if (scl_fall) begin
                        if (master_ack) begin
                            bit_cnt <= 4'h0;
                            tx_sr <= rd_next;
                            sda_oe_q <= ~rd_next[7];
                            ptr <= ptr + 8'h01;
                            state <= S_RD;
                        end else begin
                            // a nack ends the read; the pointer still moves past the byte sent
                            ptr <= ptr + 8'h01;
                            state <= S_WAIT;
                        end
                    end
                end
                S_WAIT: begin
                    // another device's frame or a finished read: stay off the line
                    sda_oe_q <= 1'b0;
                end
                default: begin
                    state <= S_IDLE;
                    sda_oe_q <= 1'b0;
                end
            endcase
        end
    end

    // taken from the stored bit, so only a host write or sys_rst can clear a fault
    assign ena_rise = main_control[`LDCR_MAIN_ENA] & ~ena_d;

    // fault latch, set wins over clear
    always @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            ena_d <= 1'b0;
            fault_q <= 1'b0;
            fault_clear_q <= 1'b0;
        end else begin
            ena_d <= main_control[`LDCR_MAIN_ENA];
            fault_clear_q <= ena_rise;
            // a fault in the clearing cycle must survive the clear
            if (fault_event && main_control[`LDCR_MAIN_FAULT_DETECT_ENABLE]) begin
                fault_q <= 1'b1;
            end else if (ena_rise) begin
                fault_q <= 1'b0;
            end
        end
    end

    // open drain: the pin is only ever pulled low, the level comes from a flop
    assign sda_out = sda_level;
    assign sda_oe = sda_oe_q;
    assign fault_latched = fault_q;
    assign fault_clear = fault_clear_q;
    assign chip_enable = main_control[`LDCR_MAIN_ENA];
    // range code, 1X treated as top range downstream
    assign photodiode_range = main_control[`LDCR_MAIN_PDR_HI:`LDCR_MAIN_PDR_LO];
    assign loop_mode_select = main_control[`LDCR_MAIN_LOOP];
    assign fault_detect_enable = main_control[`LDCR_MAIN_FAULT_DETECT_ENABLE];
    assign output_polarity = main_control[`LDCR_MAIN_POL];
    assign equalizer_enable = main_control[`LDCR_MAIN_EQ];
    assign photodiode_polarity = main_control[`LDCR_MAIN_PHOTODIODE_POLARITY];
    assign crosspoint_tempco_enable = auxiliary_control[`LDCR_AUX_CROSSPOINT_TEMPCO_ENABLE];
    assign crosspoint_range = auxiliary_control[`LDCR_AUX_CPR_HI:`LDCR_AUX_CPR_LO];
    assign crosspoint_enable = auxiliary_control[`LDCR_AUX_CROSSPOINT_ENABLE];
    // offset cancel; combination with cross-point off is not guarded here
    assign offset_cancel_disable = auxiliary_control[`LDCR_AUX_OFFSET_CANCEL_DISABLE];
    assign bias_polarity = auxiliary_control[`LDCR_AUX_BPOL];
    assign disable_mode_select = auxiliary_control[`LDCR_AUX_DMODE];
    assign serial_termination_select = auxiliary_control[`LDCR_AUX_TERM];
    assign modulation_code = {modulation_code_high, modulation_code_low};

endmodule // ldcr_regs

`default_nettype wire

// >>> ldcr_regs_chk.sv
// port checker for the laser driver control register bank
// assumes one mclk domain and an asynchronous active-high sys_rst
`default_nettype none
module ldcr_regs_chk (
    input wire logic mclk,
    input wire logic sys_rst,
    input wire logic scl_pin,
    input wire logic sda_oe,
    input wire logic fault_event,
    input wire logic fault_latched,
    input wire logic fault_clear,
    input wire logic chip_enable,
    input wire logic fault_detect_enable,
    input wire logic [9:0] modulation_code
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (sys_rst);
    logic scl_q;
    logic [3:0] since_fall;
    // chip enable, modulation code and sda_oe may only move a few cycles after a serial clock fall
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            scl_q <= 1'b1;
            since_fall <= 4'hf;
        end else begin
            scl_q <= scl_pin;
            if (scl_q && !scl_pin) since_fall <= 4'h0;
            else if (since_fall != 4'hf) since_fall <= since_fall + 4'h1;
        end
    end
    sequence ena_rise;
        !chip_enable ##1 chip_enable;
    endsequence
    sequence fault_cause;
        fault_event && fault_detect_enable;
    endsequence
    a_clear_after_ena: assert property (ena_rise |-> ##[1:2] fault_clear)
        else $error("no clear pulse after enable rise");
    a_clear_has_cause: assert property (fault_clear |-> $past(chip_enable))
        else $error("clear pulse without enable");
    a_clear_one_pulse: assert property (fault_clear |=> !fault_clear)
        else $error("clear pulse too long");
    a_latch_on_fault: assert property (fault_cause |=> fault_latched)
        else $error("fault not latched");
    a_latch_needs_cause: assert property ($rose(fault_latched) |->
        $past(fault_event && fault_detect_enable))
        else $error("latch set without enabled fault");
    a_latch_clear_cause: assert property ($fell(fault_latched) |-> fault_clear)
        else $error("latch cleared without clear pulse");
    a_cfg_on_fall: assert property (!$stable({chip_enable, modulation_code, sda_oe}) |->
        since_fall <= 4'h6)
        else $error("output moved away from serial clock fall");
    a_mod_bytes_apart: assert property (!$stable(modulation_code) |->
        ($stable(modulation_code[9:2]) || $stable(modulation_code[1:0])))
        else $error("both code bytes moved at once");
endmodule // ldcr_regs_chk
`default_nettype wire

// >>> ldcr_host.sv
// 2-wire host model: makes the serial clock, only ever pulls data low
// assumes a pull-up on the data line; clock stands high between frames
`default_nettype none
module ldcr_host (
    input wire logic mclk,
    output logic scl,
    output logic sda_low,
    input wire logic sda
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        scl = 1'b1;
        sda_low = 1'b0;
    end
    task automatic w(input int n);
        repeat (n) @(negedge mclk);
    endtask
    // 8 cycles per clock half, twice the minimum, data moves 2 cycles after fall
    task automatic bitx(input logic t, output logic r);
        scl = 1'b0;
        w(2);
        sda_low = !t;
        w(6);
        scl = 1'b1;
        w(8);
        r = sda;
    endtask
    task automatic start();
        logic d;
        bitx(1'b1, d);
        sda_low = 1'b1;
        w(8);
    endtask
    task automatic bytex(input logic [7:0] t, output logic [7:0] r, output logic n);
        for (int i = 7; i >= 0; i--) bitx(t[i], r[i]);
        bitx(1'b1, n);
    endtask
    task automatic wr(input logic [6:0] a, input logic [7:0] p, input logic [15:0] d,
        input int n, output logic nak);
        logic [7:0] r;
        logic k;
        start();
        bytex({a, 1'b0}, r, nak);
        bytex(p, r, k);
        for (int i = 0; i < n; i++) bytex(d[15 - 8 * i -: 8], r, k);
        bitx(1'b0, k);
        sda_low = 1'b0;
        w(8);
    endtask
    task automatic rd(input logic [6:0] a, input logic [7:0] p, output logic [7:0] q);
        logic [7:0] r;
        logic k;
        start();
        bytex({a, 1'b0}, r, k);
        bytex(p, r, k);
        start();
        bytex({a, 1'b1}, r, k);
        bytex(8'hff, q, k);
        bitx(1'b0, k);
        sda_low = 1'b0;
        w(8);
    endtask
endmodule // ldcr_host
`default_nettype wire

// >>> tb_ldcr_regs.sv
// self-checking bench for the laser driver control register bank
// assumes ldcr_host as serial master and a pull-up on the data line
`default_nettype none
module tb_ldcr_regs;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [6:0] DA = 7'h2a;
    logic mclk = 1'b0;
    logic sys_rst;
    logic fault_event = 1'b0;
    int n_errors = 0;
    int num_checks = 0;
    wire logic scl_pin;
    wire logic sda_low;
    wire logic sda_out;
    wire logic sda_oe;
    wire logic fault_latched;
    wire logic [7:0] mc;
    wire logic [7:0] ac;
    wire logic [9:0] modulation_code;
    wire logic sda_pin = !(sda_low || (sda_oe && !sda_out));
    always #4 mclk = ~mclk;
    ldcr_host i_ldcr_host (.mclk(mclk), .scl(scl_pin), .sda_low(sda_low), .sda(sda_pin));
    ldcr_regs #(.DEV_ADDR(DA)) i_ldcr_regs (.mclk(mclk), .sys_rst(sys_rst), .scl_pin(scl_pin),
        .sda_pin(sda_pin), .sda_out(sda_out), .sda_oe(sda_oe), .fault_event(fault_event),
        .fault_latched(fault_latched), .fault_clear(), .chip_enable(mc[7]),
        .photodiode_range(mc[6:5]), .loop_mode_select(mc[4]), .fault_detect_enable(mc[3]),
        .output_polarity(mc[2]), .equalizer_enable(mc[1]), .photodiode_polarity(mc[0]),
        .crosspoint_tempco_enable(ac[7]), .crosspoint_range(ac[6:5]),
        .crosspoint_enable(ac[4]), .offset_cancel_disable(ac[3]), .bias_polarity(ac[2]),
        .disable_mode_select(ac[1]), .serial_termination_select(ac[0]),
        .modulation_code(modulation_code));
    task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string m);
        num_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("mismatch at %0t: %s got %h exp %h", $time, m, got, exp);
        end
    endtask
    task automatic finish_test();
        $display("checks %0d mismatches %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic t_reset();
        sys_rst = 1'b1;
        repeat (2) @(negedge mclk);
        sys_rst = 1'b0;
        repeat (4) @(negedge mclk);
        chk({mc, ac}, 16'h0000, "reset value");
        chk({4'h0, sda_oe, fault_latched, modulation_code}, 16'h0000, "reset outputs");
        $display("test reset done");
    endtask
    task automatic t_ctrl();
        logic [7:0] m;
        logic [7:0] a;
        logic [7:0] r0;
        logic [7:0] r1;
        logic k;
        for (int i = 0; i < 8; i++) begin
            m = 8'h01 << i;
            // offset cancel disable only with cross-point on, as the host must
            a = (i == 3) ? 8'h18 : m;
            i_ldcr_host.wr(DA, 8'h00, {m, a}, 2, k);
            chk({mc, ac}, {m, a}, "control bits");
            chk({14'h0000, mc[6:5]}, {14'h0000, m[6:5]}, "pd range");
            chk({15'h0000, mc[4]}, {15'h0000, m[4]}, "loop mode");
            chk({15'h0000, mc[3]}, {15'h0000, m[3]}, "fault enable");
            chk({15'h0000, mc[1]}, {15'h0000, m[1]}, "equalizer");
            chk({15'h0000, mc[0]}, {15'h0000, m[0]}, "pd polarity");
            chk({15'h0000, ac[7]}, {15'h0000, a[7]}, "tempco");
            chk({14'h0000, ac[6:5]}, {14'h0000, a[6:5]}, "cp range");
            chk({15'h0000, ac[4]}, {15'h0000, a[4]}, "cp enable");
            chk({15'h0000, ac[3]}, {15'h0000, a[3]}, "offset cancel");
            chk({15'h0000, ac[2]}, {15'h0000, a[2]}, "bias polarity");
            chk({15'h0000, ac[0]}, {15'h0000, a[0]}, "termination");
            i_ldcr_host.rd(DA, 8'h00, r0);
            i_ldcr_host.rd(DA, 8'h01, r1);
            chk({r0, r1}, {m, a}, "control read");
        end
        $display("test control done");
    endtask
    task automatic t_mod();
        logic [7:0] r;
        logic k;
        i_ldcr_host.wr(DA, 8'h02, 16'hff5a, 2, k);
        chk({6'h00, modulation_code}, {6'h00, 8'h5a, 2'h3}, "code");
        i_ldcr_host.rd(DA, 8'h02, r);
        i_ldcr_host.wr(DA, 8'h04, 16'h7700, 1, k);
        chk({r, 6'h00, modulation_code[1:0]}, 16'h0303, "code low");
        i_ldcr_host.rd(DA, 8'h04, r);
        chk({8'h00, r}, 16'h0000, "unmapped read");
        $display("test code done");
    endtask
    task automatic pulse();
        @(negedge mclk) fault_event = 1'b1;
        @(negedge mclk) fault_event = 1'b0;
        repeat (2) @(negedge mclk);
    endtask
    task automatic t_fault();
        logic k;
        i_ldcr_host.wr(DA, 8'h00, 16'h0800, 1, k);
        pulse();
        chk({15'h0000, fault_latched}, 16'h0001, "latch set");
        i_ldcr_host.wr(DA, 8'h00, 16'h8800, 1, k);
        chk({15'h0000, fault_latched}, 16'h0000, "latch clear");
        i_ldcr_host.wr(DA, 8'h00, 16'h8000, 1, k);
        pulse();
        chk({15'h0000, fault_latched}, 16'h0000, "detect off");
        i_ldcr_host.wr(DA ^ 7'h01, 8'h00, 16'h0800, 1, k);
        chk({k, 7'h00, mc}, 16'h8080, "wrong address");
        $display("test fault done");
    endtask
    initial begin
        t_reset();
        t_ctrl();
        t_mod();
        t_fault();
        // a mid-run reset must bring every register back to zero
        t_reset();
        finish_test();
    end
    initial begin
        repeat (100000) @(posedge mclk);
        n_errors++;
        $display("mismatch at %0t: run too long", $time);
        finish_test();
    end
endmodule // tb_ldcr_regs
bind ldcr_regs ldcr_regs_chk i_ldcr_regs_chk (.mclk(mclk), .sys_rst(sys_rst),
    .scl_pin(scl_pin), .sda_oe(sda_oe), .fault_event(fault_event),
    .fault_latched(fault_latched), .fault_clear(fault_clear), .chip_enable(chip_enable),
    .fault_detect_enable(fault_detect_enable), .modulation_code(modulation_code));
`default_nettype wire
